/* File: hdl/pscr_bridge.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pscr_defs.svh"

module pscr_bridge #(
  parameter int NUM_PERIPH = `PSCR_NUM_PERIPH
) (
  // Clock and reset.
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  // System side request and answer.
  input  wire pscr_pkg::pscr_req_type req,
  output logic                        req_ready_q,
  output logic                        rsp_valid_q,
  output logic [31:0]                 rsp_rdata_q,
  output logic                        rsp_err_q,
  // Peripheral bus strobes, as seen by the peripherals.
  output logic                        psel_q,
  output logic                        penable_q,
  output logic                        pwrite_q,
  output logic [31:0]                 paddr_q,
  output logic [31:0]                 pwdata_q,
  // Stored words of each window, one per peripheral plus interrupts.
  output logic [NUM_PERIPH:0][31:0]   ctl_q
);

  // Window and offset widths, and the view offsets at the offset width.
  localparam int            OW      = `PSCR_WIN_BITS;
  localparam int            IW      = `PSCR_IRQC_WIN_BITS;
  localparam int            PW      = 32 - OW;
  localparam int            QW      = 32 - IW;
  localparam logic [OW-1:0] OFS_SET = OW'(`PSCR_OFS_SET);
  localparam logic [OW-1:0] OFS_CLR = OW'(`PSCR_OFS_CLR);
  localparam logic [OW-1:0] OFS_RD  = OW'(`PSCR_OFS_RD);

  pscr_pkg::pscr_state_type state_q;
  pscr_pkg::pscr_req_type   hold_q;
  logic [NUM_PERIPH:0]      hit;
  logic                     any_hit;
  logic [31:0]              rd_mux;
  logic [OW-1:0]            ofs;

  // Peripheral windows are 16 Kbyte, stacked from the region base; the
  // interrupt controller has its own 4 Kbyte window at the very top.
  always_comb begin
    hit = '0;
    for (int i = 0; i < NUM_PERIPH; i++) begin
      hit[i] = (hold_q.addr[31:OW] ==
                PW'((`PSCR_REGION_BASE >> OW) + i));
    end
    hit[NUM_PERIPH] = (hold_q.addr[31:IW] ==
                       QW'(`PSCR_IRQC_BASE >> IW));
  end
  assign any_hit = |hit;
  // Offset counts upward from the window's lowest address. Ordinary
  // windows keep all their offset bits, so no register shows up again at
  // a 4 Kbyte alias; the interrupt window only has the lower bits.
  assign ofs = hit[NUM_PERIPH] ? OW'(hold_q.addr[IW-1:0]) :
                                 hold_q.addr[OW-1:0];

  // Each window has a set/clear/read triple at its bottom.
  genvar g;
  generate
    for (g = 0; g <= NUM_PERIPH; g++) begin : g_win
      logic acc;
      assign acc = (state_q == pscr_pkg::PSCR_ACCESS) && hit[g] &&
                   hold_q.write;
      pscr_setclr_reg #(.WIDTH(32)) u_reg (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .set_stb  (acc && ofs == OFS_SET),
        .clr_stb  (acc && ofs == OFS_CLR),
        .wdata    (hold_q.wdata),
        .value_q  (ctl_q[g])
      );
    end
  endgenerate

  // Only the read view returns the word; set and clear views read zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i <= NUM_PERIPH; i++) begin
      if (hit[i] && ofs == OFS_RD) begin
        rd_mux = ctl_q[i];
      end
    end
  end

  // Two-phase peripheral sequence: setup then access, one cycle each.
  // The request is taken only in idle, so a held request is not taken again while setup and access run.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= pscr_pkg::PSCR_IDLE;
      hold_q  <= '0;
    end else begin
      case (state_q)
        pscr_pkg::PSCR_IDLE: begin
          if (req.valid) begin
            hold_q  <= req;
            state_q <= pscr_pkg::PSCR_SETUP;
          end
        end
        pscr_pkg::PSCR_SETUP: state_q <= pscr_pkg::PSCR_ACCESS;
        pscr_pkg::PSCR_ACCESS: state_q <= pscr_pkg::PSCR_IDLE;
        default: state_q <= pscr_pkg::PSCR_IDLE;
      endcase
    end
  end

  // Peripheral bus outputs follow the sequencer, all registered.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      psel_q    <= 1'b0;
      penable_q <= 1'b0;
      pwrite_q  <= 1'b0;
      paddr_q   <= 32'h0000_0000;
      pwdata_q  <= 32'h0000_0000;
    end else begin
      psel_q    <= (state_q == pscr_pkg::PSCR_IDLE && req.valid) ||
                   state_q == pscr_pkg::PSCR_SETUP;
      penable_q <= state_q == pscr_pkg::PSCR_SETUP;
      if (state_q == pscr_pkg::PSCR_IDLE && req.valid) begin
        pwrite_q <= req.write;
        paddr_q  <= req.addr;
        // Byte lanes pass straight; byte 0 sits in bits 7:0.
        pwdata_q <= req.wdata;
      end
    end
  end

  // Answer one cycle after the access phase; unmapped flags an error.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 32'h0000_0000;
      rsp_err_q   <= 1'b0;
    end else begin
      req_ready_q <= state_q == pscr_pkg::PSCR_IDLE && req.valid;
      rsp_valid_q <= state_q == pscr_pkg::PSCR_ACCESS;
      rsp_err_q   <= state_q == pscr_pkg::PSCR_ACCESS && !any_hit;
      if (state_q == pscr_pkg::PSCR_ACCESS) begin
        rsp_rdata_q <= hold_q.write ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Checks.
  property p_setup_access;
    @(posedge core_clk) disable iff (sys_rst)
      psel_q && !penable_q |=> psel_q && penable_q;
  endproperty
  a_setup_access: assert property (p_setup_access)
    else $error("Access phase did not follow setup.");

  property p_rsp_after;
    @(posedge core_clk) disable iff (sys_rst)
      req_ready_q |-> ##2 rsp_valid_q;
  endproperty
  a_rsp_after: assert property (p_rsp_after)
    else $error("Answer not two cycles after acceptance.");

  property p_set_bits;
    @(posedge core_clk) disable iff (sys_rst)
      (state_q == pscr_pkg::PSCR_ACCESS && hold_q.write && hit[0] &&
       ofs == OFS_SET) |=> ((ctl_q[0] & $past(hold_q.wdata)) ==
                                  $past(hold_q.wdata));
  endproperty
  a_set_bits: assert property (p_set_bits)
    else $error("Set write left a bit clear.");

  property p_clr_bits;
    @(posedge core_clk) disable iff (sys_rst)
      (state_q == pscr_pkg::PSCR_ACCESS && hold_q.write && hit[0] &&
       ofs == OFS_CLR) |=> ((ctl_q[0] & $past(hold_q.wdata)) == 0);
  endproperty
  a_clr_bits: assert property (p_clr_bits)
    else $error("Clear write left a bit set.");

  property p_keep_zero;
    @(posedge core_clk) disable iff (sys_rst)
      (state_q == pscr_pkg::PSCR_ACCESS && hold_q.write && hit[0])
      |=> ((ctl_q[0] & ~$past(hold_q.wdata)) ==
           ($past(ctl_q[0]) & ~$past(hold_q.wdata)));
  endproperty
  a_keep_zero: assert property (p_keep_zero)
    else $error("Zero data bit changed a stored bit.");

  property p_rd_view;
    @(posedge core_clk) disable iff (sys_rst)
      (state_q == pscr_pkg::PSCR_ACCESS && !hold_q.write && hit[1] &&
       ofs == OFS_RD) |=> rsp_rdata_q == $past(ctl_q[1]);
  endproperty
  a_rd_view: assert property (p_rd_view)
    else $error("Read view did not return stored word.");

  property p_setview_zero;
    @(posedge core_clk) disable iff (sys_rst)
      (state_q == pscr_pkg::PSCR_ACCESS && !hold_q.write &&
       ofs != OFS_RD) |=> rsp_rdata_q == 0;
  endproperty
  a_setview_zero: assert property (p_setview_zero)
    else $error("Set or clear view read nonzero.");

  property p_irqc_win;
    @(posedge core_clk) disable iff (sys_rst)
      (state_q == pscr_pkg::PSCR_ACCESS && hold_q.write &&
       hold_q.addr == `PSCR_IRQC_BASE + 32'(`PSCR_OFS_SET))
      |=> ((ctl_q[NUM_PERIPH] & $past(hold_q.wdata)) ==
           $past(hold_q.wdata));
  endproperty
  a_irqc_win: assert property (p_irqc_win)
    else $error("Interrupt window set view did not set bits.");

  property p_unmapped;
    @(posedge core_clk) disable iff (sys_rst)
      (state_q == pscr_pkg::PSCR_ACCESS &&
       hold_q.addr < `PSCR_REGION_BASE) |=> rsp_err_q;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped access gave no error.");

  c_write: cover property (@(posedge core_clk) psel_q && pwrite_q);
  c_read: cover property (@(posedge core_clk) rsp_valid_q && !rsp_err_q);
  c_err: cover property (@(posedge core_clk) rsp_err_q);

endmodule
`default_nettype wire

/* File: hdl/pscr_defs.svh */
`ifndef PSCR_DEFS_SVH
`define PSCR_DEFS_SVH

// Address map of the peripheral region.
`define PSCR_REGION_BASE   32'hffd0_0000
`define PSCR_WIN_BITS      14
`define PSCR_IRQC_WIN_BITS 12
`define PSCR_NUM_PERIPH    4
`define PSCR_IRQC_BASE     32'hffff_f000

// Offsets of the set, clear and read views inside one window.
`define PSCR_OFS_SET       12'h000
`define PSCR_OFS_CLR       12'h004
`define PSCR_OFS_RD        12'h008

// Reset value of every stored control word.
`define PSCR_CTL_RESET     32'h0000_0000

`endif

/* File: hdl/pscr_pkg.sv */
package pscr_pkg;

  // Request as seen on the system side.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pscr_req_type;

  // Bridge sequencer states.
  typedef enum logic [1:0] {
    PSCR_IDLE   = 2'b00,
    PSCR_SETUP  = 2'b01,
    PSCR_ACCESS = 2'b10
  } pscr_state_type;

endpackage

/* File: hdl/pscr_setclr_reg.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pscr_defs.svh"

module pscr_setclr_reg #(
  parameter int WIDTH = 32
) (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Access strobes from the decoder.
  input  wire logic             set_stb,
  input  wire logic             clr_stb,
  input  wire logic [WIDTH-1:0] wdata,
  // Stored value.
  output logic      [WIDTH-1:0] value_q
);

  // Ones set or clear their bit, zeros leave it, so no read-modify-write.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      value_q <= WIDTH'(`PSCR_CTL_RESET);
    end else if (set_stb) begin
      value_q <= value_q | wdata;
    end else if (clr_stb) begin
      value_q <= value_q & ~wdata;
    end
  end

endmodule
`default_nettype wire

/* File: tb/pscr_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pscr_cpu_model (
  // Clock.
  input  wire logic              core_clk,
  // Request towards the bridge and its acceptance.
  output var pscr_pkg::pscr_req_type req,
  input  wire logic              req_ready_q
);
  // Idle bus at time zero.
  initial req = '0;

  // One word transfer; the request stands until the bridge accepts it or 8 cycles pass.
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic ok);
    int n;
    ok = 1'b0;
    @(negedge core_clk);
    req <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
    for (n = 0; n < 8 && !ok; n++) begin
      @(negedge core_clk);
      ok = (req_ready_q === 1'b1);
    end
    // Released fields flip so a stale address never looks valid.
    req.valid <= 1'b0;
    req.addr  <= ~a;
    req.wdata <= ~d;
  endtask
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pscr_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module testbench;
  localparam int NP = 4;
  logic                   core_clk, sys_rst, ok;
  pscr_pkg::pscr_req_type req;
  logic                   req_ready_q, rsp_valid_q, rsp_err_q;
  logic                   psel_q, penable_q, pwrite_q;
  logic [31:0]            rsp_rdata_q, paddr_q, pwdata_q, d, m, top;
  logic [NP:0][31:0]      ctl_q;
  logic [32:0]            expq[$];
  logic [32:0]            exp_e;
  int                     fail_count, checked, i;

  pscr_bridge #(.NUM_PERIPH(NP)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .req(req),
    .req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q),
    .rsp_rdata_q(rsp_rdata_q), .rsp_err_q(rsp_err_q), .psel_q(psel_q),
    .penable_q(penable_q), .pwrite_q(pwrite_q), .paddr_q(paddr_q),
    .pwdata_q(pwdata_q), .ctl_q(ctl_q));

  pscr_cpu_model cpu (
    .core_clk(core_clk), .req(req), .req_ready_q(req_ready_q));

  // Free running 20 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Lowest address of window i; the last index is the interrupt window.
  function automatic logic [31:0] base(input int k);
    if (k == NP) return `PSCR_IRQC_BASE;
    return `PSCR_REGION_BASE + 32'(k) * 32'h0000_4000;
  endfunction

  // Notes the expected answer first, so the watcher can match it.
  task automatic acc(input logic wr, input logic [31:0] a, dd,
                     input logic [32:0] e);
    expq.push_back(e);
    cpu.xfer(wr, a, dd, ok);
    if (!ok) begin
      fail_count++;
      report_and_stop();
    end else begin
      // Acceptance was just seen, so the setup phase stands right now.
      `CHK("sel en", 2'b10, {psel_q, penable_q})
      `CHK("paddr", a, paddr_q)
      `CHK("pwrite", wr, pwrite_q)
      `CHK("pwdata", dd, pwdata_q)
    end
  endtask

  // Answers are checked mid-cycle, where the one-cycle pulse is settled.
  always @(negedge core_clk) begin
    if (rsp_valid_q === 1'b1) begin
      if (expq.size() == 0) begin
        fail_count++;
        $display("wrong value rsp expected none seen %h", rsp_rdata_q);
      end else begin
        exp_e = expq.pop_front();
        `CHK("rsp", exp_e, {rsp_err_q, rsp_rdata_q})
      end
    end
  end

  // Main sequence: every window, then addresses outside the map.
  initial begin
    sys_rst = 1'b1;
    fail_count = 0;
    checked = 0;
    void'($urandom(32));
    repeat (8) @(posedge core_clk);
    @(negedge core_clk) sys_rst = 1'b0;
    for (i = 0; i <= NP; i++) `CHK("ctl reset", 32'h0, ctl_q[i])
    for (i = 0; i <= NP; i++) begin
      d = $urandom;
      m = $urandom;
      top = (i == NP) ? 32'h0000_0ffc : 32'h0000_3ffc;
      acc(1'b1, base(i) + `PSCR_OFS_SET, d, 33'h0);
      acc(1'b1, base(i) + `PSCR_OFS_CLR, m, 33'h0);
      acc(1'b0, base(i) + `PSCR_OFS_RD, $urandom, {1'b0, d & ~m});
      acc(1'b0, base(i) + `PSCR_OFS_SET, $urandom, 33'h0);
      acc(1'b0, base(i) + `PSCR_OFS_CLR, $urandom, 33'h0);
      // A 4 Kbyte alias of the set view must not touch the stored word.
      if (i < NP) acc(1'b1, base(i) + 32'h0000_1000, 32'hffff_ffff, 33'h0);
      // The last word of a window is still inside it, so no error.
      acc(1'b1, base(i) + top, 32'hffff_ffff, 33'h0);
      acc(1'b0, base(i) + `PSCR_OFS_RD, 32'h0, {1'b0, d & ~m});
      `CHK("ctl", d & ~m, ctl_q[i])
    end
    acc(1'b0, base(NP - 1) + 32'h0000_4008, 32'h0, {1'b1, 32'h0});
    acc(1'b1, `PSCR_IRQC_BASE - 32'h4, $urandom, {1'b1, 32'h0});
    acc(1'b0, 32'h0000_0008, 32'h0, {1'b1, 32'h0});
    for (i = 0; i < 20 && expq.size() > 0; i++) @(negedge core_clk);
    if (expq.size() > 0) fail_count++;
    report_and_stop();
  end
endmodule

`default_nettype wire
